/* File: hdl/lws_lane.sv */
// What this block does
// - tx_word_ready is high whenever the lane can take a new word.
// - each received word is passed up with a one-cycle rx_word_valid.
// - a lane status notice carrying the current status is issued whenever the status changes.
// - the serialiser side has separate tx and rx paths of width 10, 20 or 40 bits.
// - the tx parallel word carries one, two or four whole ten-bit symbols.
// - the rx parallel word is unaligned and may span parts of adjacent symbols.
// - a one-bit flag reports whether a signal is present at the receiver.
// - symbols on the serialiser side pass as given with no line coding; the lane logic only aligns them on rx.
module lws_lane
	import lws_pkg::*;
#(
	parameter int               SER_W     = SER_W_WIDE,
	parameter logic [SYM_W-1:0] COMMA_SYM = COMMA_SYM_RST,
	parameter logic [SYM_W-1:0] LLCW_SYM  = LLCW_SYM_RST,
	parameter logic [SYM_W-1:0] IDLE_SYM  = IDLE_SYM_RST
) (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic [WORD_W-1:0] tx_word,
	input  wire logic              tx_word_valid,
	output logic                   tx_word_ready,
	output logic      [WORD_W-1:0] rx_word,
	output logic                   rx_word_valid,
	output logic                   lane_ready,
	output logic                   lane_status_change,
	output logic      [SER_W-1:0]  serial_tx_symbols,
	input  wire logic [SER_W-1:0]  serial_rx_bits,
	input  wire logic              rx_signal,
	output logic                   rx_signal_present
);
	localparam int NCH = WORD_W / SER_W;
	localparam int NSY = SER_W / SYM_W;
	localparam int IDX_W = 2;
	localparam logic [IDX_W-1:0] LAST_CH = IDX_W'(NCH - 1);
	localparam logic [WORD_W-1:0] IDLE_WORD = {IDLE_SYM, IDLE_SYM, LLCW_SYM, COMMA_SYM};

	logic [IDX_W-1:0]  idx_q, idx_d;
	logic [WORD_W-1:0] sh_q, sh_d;
	logic [SER_W-1:0]  out_q, out_d;
	logic              load;
	logic [WORD_W-1:0] next_word;

	logic [SER_W-1:0]  al_bits;
	logic              al_locked;
	logic              al_locked_q;
	logic [WORD_W-1:0] acc_q, acc_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [WORD_W-1:0] rxw_q, rxw_d;
	logic              rxv_q, rxv_d;
	logic              sig_q;
	logic              stat_q;
	logic              chg_q;
	logic              stat_now;

	// tx gearbox: a new word is taken only on the last chunk of the current one
	assign load          = (idx_q == LAST_CH);
	assign tx_word_ready = load;
	// no word offered means idle fill, so the line never stops carrying commas
	assign next_word     = (tx_word_valid && tx_word_ready) ? tx_word : IDLE_WORD;

	always_comb begin
		if (load) begin
			out_d = next_word[SER_W-1:0];
			sh_d  = next_word >> SER_W;
			idx_d = '0;
		end else begin
			out_d = sh_q[SER_W-1:0];
			sh_d  = sh_q >> SER_W;
			idx_d = idx_q + IDX_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			idx_q <= LAST_CH;
			sh_q  <= '0;
			out_q <= '0;
		end else begin
			idx_q <= idx_d;
			sh_q  <= sh_d;
			out_q <= out_d;
		end
	end

	assign serial_tx_symbols = out_q;

	lws_rx_aligner #(
		.SER_W     (SER_W),
		.COMMA_SYM (COMMA_SYM)
	) u_align (
		.core_clk       (core_clk),
		.resetn         (resetn),
		.raw_bits       (serial_rx_bits),
		.signal_present (rx_signal),
		.aligned_bits   (al_bits),
		.locked         (al_locked)
	);

	// a comma always opens a word in the low symbol; a partial word is dropped
	always_comb begin
		acc_d = acc_q;
		cnt_d = cnt_q;
		rxw_d = rxw_q;
		rxv_d = 1'b0;
		// both lock stages gate: the first cycle after lock still carries bits from before the signal returned
		if (al_locked_q && al_locked) begin
			for (int s = 0; s < NSY; s++) begin
				if (al_bits[s*SYM_W +: SYM_W] == COMMA_SYM) begin
					acc_d = {{(WORD_W-SYM_W){1'b0}}, al_bits[s*SYM_W +: SYM_W]};
					cnt_d = CNT_W'(1);
				end else if (cnt_d != '0) begin
					acc_d[cnt_d*SYM_W +: SYM_W] = al_bits[s*SYM_W +: SYM_W];
					cnt_d = cnt_d + CNT_W'(1);
				end
				if (cnt_d == CNT_W'(SYM_PER_WORD)) begin
					rxw_d = acc_d;
					rxv_d = 1'b1;
					cnt_d = '0;
				end
			end
		end else begin
			cnt_d = '0;
		end
	end

	assign stat_now = al_locked && rx_signal;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			al_locked_q <= 1'b0;
			acc_q       <= '0;
			cnt_q       <= '0;
			rxw_q       <= '0;
			rxv_q       <= 1'b0;
			sig_q       <= 1'b0;
			stat_q      <= STATUS_RST;
			chg_q       <= 1'b0;
		end else begin
			al_locked_q <= al_locked;
			acc_q       <= acc_d;
			cnt_q       <= cnt_d;
			rxw_q       <= rxw_d;
			rxv_q       <= rxv_d;
			sig_q       <= rx_signal;
			stat_q      <= stat_now;
			chg_q       <= (stat_now != stat_q);
		end
	end

	assign rx_word            = rxw_q;
	assign rx_word_valid      = rxv_q;
	assign rx_signal_present  = sig_q;
	assign lane_ready         = stat_q;
	assign lane_status_change = chg_q;
endmodule // lws_lane

/* File: hdl/lws_pkg.sv */
package lws_pkg;
	localparam int SYM_W        = 10;
	localparam int SYM_PER_WORD = 4;
	localparam int WORD_W       = SYM_W * SYM_PER_WORD;
	localparam int SER_W_NARROW = 10;
	localparam int SER_W_MID    = 20;
	localparam int SER_W_WIDE   = 40;
	localparam int OFF_W        = 4;
	localparam int CNT_W        = 3;
	localparam logic [SYM_W-1:0] COMMA_SYM_RST = 10'h0F8;
	localparam logic [SYM_W-1:0] LLCW_SYM_RST  = 10'h1A6;
	localparam logic [SYM_W-1:0] IDLE_SYM_RST  = 10'h2B5;
	localparam logic             STATUS_RST    = 1'b0;
endpackage

/* File: hdl/lws_rx_aligner.sv */
module lws_rx_aligner
	import lws_pkg::*;
#(
	parameter int                SER_W     = SER_W_WIDE,
	parameter logic [SYM_W-1:0]  COMMA_SYM = COMMA_SYM_RST
) (
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [SER_W-1:0] raw_bits,
	input  wire logic             signal_present,
	output logic      [SER_W-1:0] aligned_bits,
	output logic                  locked
);
	logic [SER_W-1:0]   prev_q;
	logic [OFF_W-1:0]   off_q;
	logic               lock_q;
	logic [SER_W-1:0]   al_q;
	logic [2*SER_W-1:0] win;
	logic               hit;
	logic [OFF_W-1:0]   hit_off;
	logic [OFF_W-1:0]   use_off;

	// older bits sit low: bit 0 left the line first
	assign win = {raw_bits, prev_q};

	// a chunk may hold the tail of one symbol and the head of the next
	always_comb begin
		hit = 1'b0;
		hit_off = '0;
		for (int p = SER_W - 1; p >= 0; p--) begin
			if (win[p +: SYM_W] == COMMA_SYM) begin
				hit = 1'b1;
				hit_off = OFF_W'(p % SYM_W);
			end
		end
	end

	assign use_off = (!lock_q && hit) ? hit_off : off_q;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			prev_q <= '0;
			off_q  <= '0;
			lock_q <= 1'b0;
			al_q   <= '0;
		end else begin
			prev_q <= raw_bits;
			al_q   <= win[use_off +: SER_W];
			// lock is only dropped on loss of signal, never on a stray comma
			if (!signal_present) begin
				lock_q <= 1'b0;
			end else if (!lock_q && hit) begin
				lock_q <= 1'b1;
				off_q  <= hit_off;
			end
		end
	end

	assign aligned_bits = al_q;
	assign locked       = lock_q;
endmodule // lws_rx_aligner

/* File: tb/lws_lane_sva.sv */
module lws_lane_sva
	import lws_pkg::*;
#(parameter int SER_W = SER_W_WIDE) (
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire logic [WORD_W-1:0] tx_word,
	input wire logic              tx_word_valid,
	input wire logic              tx_word_ready,
	input wire logic [WORD_W-1:0] rx_word,
	input wire logic              rx_word_valid,
	input wire logic              lane_ready,
	input wire logic              lane_status_change,
	input wire logic [SER_W-1:0]  serial_tx_symbols,
	input wire logic              rx_signal,
	input wire logic              rx_signal_present
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	wire take = tx_word_valid && tx_word_ready;
	// written for two chunks a word, the width the bench runs
	a_ready_gap: assert property (tx_word_ready |=> !tx_word_ready ##1 tx_word_ready)
		else $error("ready spacing wrong");
	a_first_chunk: assert property (take |=> serial_tx_symbols == $past(tx_word[SER_W-1:0]))
		else $error("first chunk wrong");
	a_last_chunk: assert property (take |-> ##2
		serial_tx_symbols == $past(tx_word[WORD_W-1:WORD_W-SER_W], 2)) else $error("last chunk wrong");
	a_rx_single: assert property (rx_word_valid |=> !rx_word_valid)
		else $error("rx valid too long");
	a_rx_comma: assert property (rx_word_valid |-> rx_word[SYM_W-1:0] == COMMA_SYM_RST)
		else $error("rx word misaligned");
	a_change_pulse: assert property ($changed(lane_ready) |-> lane_status_change)
		else $error("status change missed");
	a_pulse_cause: assert property (lane_status_change |-> $changed(lane_ready) ##1 !lane_status_change)
		else $error("spurious status pulse");
	a_sig_follow: assert property ($past(resetn) |-> rx_signal_present == $past(rx_signal))
		else $error("signal flag wrong");
	a_loss_drop: assert property (!rx_signal |-> ##[1:2] !lane_ready)
		else $error("ready kept without signal");
endmodule // lws_lane_sva
bind lws_lane lws_lane_sva #(.SER_W(SER_W)) u_lane_sva (.*);

/* File: tb/lws_serdes_model.sv */
module lws_serdes_model
	import lws_pkg::*;
#(parameter int SER_W = SER_W_MID, parameter int SKEW = 3) (
	input  wire logic             core_clk,
	input  wire logic             link_up,
	input  wire logic [SER_W-1:0] serial_tx_symbols,
	output logic      [SER_W-1:0] serial_rx_bits,
	output logic                  rx_signal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [SER_W-1:0] prev_q;
	wire [2*SER_W-1:0] pair = {serial_tx_symbols, prev_q};
	always_ff @(posedge core_clk) prev_q <= serial_tx_symbols;
	// loopback cut off the symbol grid; without signal the line shows inverted junk
	assign serial_rx_bits = link_up ? pair[SKEW +: SER_W] : ~pair[SKEW +: SER_W];
	assign rx_signal = link_up;
endmodule // lws_serdes_model

/* File: tb/tb_lane_word_serdes_interface.sv */
module tb_lane_word_serdes_interface
	import lws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = SER_W_MID;
	localparam logic [WORD_W-1:0] IDLE_W = {IDLE_SYM_RST, IDLE_SYM_RST, LLCW_SYM_RST, COMMA_SYM_RST};
	logic              core_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              link_up = 1'b0;
	logic              tx_word_valid = 1'b0;
	logic [WORD_W-1:0] tx_word = '0;
	logic [WORD_W-1:0] rx_word;
	logic [W-1:0]      serial_tx_symbols, serial_rx_bits;
	logic              tx_word_ready, rx_word_valid, lane_ready, lane_status_change;
	logic              rx_signal, rx_signal_present;
	logic [WORD_W-1:0] exp_q[$];
	int                failures = 0;
	int                compares = 0;
	always #2 core_clk = ~core_clk;
	lws_lane #(.SER_W(W)) DUT (.*);
	lws_serdes_model #(.SER_W(W)) u_serdes (.*);
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			failures++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic complete_run;
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// masked symbols never hold a run of ones, so no false comma appears
	function automatic logic [SYM_W-1:0] rs();
		return SYM_W'($urandom) & 10'h155;
	endfunction
	task automatic send(input logic [WORD_W-1:0] w);
		int n;
		n = 0;
		tx_word = w;
		tx_word_valid = 1'b1;
		exp_q.push_back(w);
		while (tx_word_ready !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		@(negedge core_clk);
	endtask
	task automatic settle;
		int n;
		n = 0;
		while ((lane_ready !== 1'b1 || exp_q.size() != 0) && n < 100) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	always @(negedge core_clk) if (rx_word_valid === 1'b1 && rx_word !== IDLE_W) begin
		if (exp_q.size() == 0)
			check(1'b0, "unexpected word");
		else
			check(rx_word === exp_q.pop_front(), "word mismatch");
	end
	initial begin
		void'($urandom(32'h3781));
		repeat (10) @(negedge core_clk);
		resetn = 1'b1;
		link_up = 1'b1;
		for (int r = 0; r < 2; r++) begin
			settle();
			check(lane_ready === 1'b1, "lane never ready");
			for (int i = 0; i < 12; i++) begin
				send({rs(), rs(), rs(), COMMA_SYM_RST});
				if ($urandom_range(1, 0) == 1) begin
					tx_word_valid = 1'b0;
					repeat ($urandom_range(3, 1)) @(negedge core_clk);
				end
			end
			tx_word_valid = 1'b0;
			settle();
			check(exp_q.size() == 0, "words lost");
			link_up = 1'b0;
			repeat (4) @(negedge core_clk);
			check(lane_ready === 1'b0, "lane still ready");
			check(rx_signal_present === 1'b0, "signal flag stuck");
			link_up = 1'b1;
		end
		complete_run();
	end
	initial begin
		#20000;
		failures++;
		complete_run();
	end
endmodule // tb_lane_word_serdes_interface
